// ---- hdl/xcvr_cfg_regs.sv ----
// Purpose: configuration store with a 4-wire serial link
// Assumes: link_sck runs only inside frames, select is active low
// Notes:   link words cross by toggle handshake; writes enter a two-entry buffer
// Function
// - sixteen buffer bytes, six control bytes, read/write
// - one status byte, read only
// - contents kept while powered, lost at off
// - turn-on events restore control defaults
// - receive irq on error or fill threshold
// - transmit irq on empty or remaining threshold
// - bit five enables analog supply
// - bit four selects band
// - bits two to one pick mode
// - transparent bit bypasses buffer via pins
// - second register bits seven to one tune low
// - tuning step is crystal over 16384
// - bit-check success irq unless bit zero set
// - transmit uses manchester unless bit zero set
`timescale 1ns/10ps
`default_nettype none
module xcvr_cfg_regs (
	input  wire logic                   ref_clk,           // core clock 100 mhz
	input  wire logic                   reset_n,           // reset, low; sync in core, async on link side
	input  wire logic                   link_sck,          // serial clock
	input  wire logic                   link_cs_n,         // frame select, low
	input  wire logic                   serial_in_tx_mod,  // serial data in
	output logic                        serial_out_rx_mod, // serial data out
	output logic                        serial_out_en,     // drive enable
	input  wire logic                   power_on_pin,      // wake, high
	input  wire logic [4:0]             button_input_n,    // wake, low
	input  wire logic                   aux_supply_pin,    // aux above limit
	input  wire logic                   cfg_hold,          // stall updates
	input  wire logic [4:0]             fill_count,        // buffer bytes
	input  wire logic                   rx_error,          // receive error
	input  wire logic                   bit_check_ok,      // bit check passed
	input  wire logic                   tx_empty,          // tx buffer empty
	input  wire logic                   rx_mod_data,       // receive stream
	output logic                        tx_mod_data,       // transmit stream
	output logic                        irq,               // interrupt pin
	output logic                        analog_supply,     // supply switch
	output logic                        band_select,       // 1 = low band
	output xcvr_cfg_pkg::op_mode_t      op_sel,            // operating mode
	output logic                        transparent,       // buffer bypass
	output logic [12:0]                 freq_word,         // rf tuning word
	output logic                        manchester_on,     // tx coding
	output logic                        digital_on         // not off mode
);
	import xcvr_cfg_pkg::*;

	// link domain state
	link_state_t    lstate_q;          // frame phase
	logic [2:0]     bit_q;             // bit within byte
	logic [7:0]     in_q;              // incoming shift
	logic [7:0]     out_q;             // outgoing shift
	link_word_t     lword_q;           // word held during handshake
	logic           req_q;             // request toggle
	logic [2:0]     ack_s;             // ack synchroniser
	logic           fire;              // send a word now

	// core domain state
	logic [8:0]     pin_s1, pin_s2, pin_s3; // input synchronisers
	logic [8:0]     pin_q;             // filtered inputs
	logic           seen_q;            // last request taken
	logic           ack_q;             // ack toggle
	logic [7:0]     rd_q;              // read answer
	link_word_t     fifo_q [2];        // write buffer
	logic           wp_q, rp_q;        // pointers
	logic [1:0]     cnt_q;             // entries held
	logic [7:0]     buf_q [BUF_NUM];   // data buffer
	logic [7:0]     ctrl_q [CTRL_NUM]; // control bytes
	logic           irq_q;             // sticky interrupt
	logic           off_q;             // off mode
	logic [2:0]     wake_q;            // wake cause: aux, button, power

	// link side: byte boundary and handshake state
	wire            byte_end  = (bit_q == 3'h7);
	wire [7:0]      in_next   = {in_q[6:0], serial_in_tx_mod};
	wire            busy      = (req_q != ack_s[2]) | (ack_s[1] != ack_s[2]);

	// frame logic, cleared by the frame's own select
	always_ff @(posedge link_sck or posedge link_cs_n) begin
		if (link_cs_n) begin
			lstate_q <= L_CMD;
			bit_q    <= 3'h0;
			in_q     <= 8'h00;
			out_q    <= 8'h00;
		end else begin
			bit_q <= bit_q + 3'h1;
			in_q  <= in_next;
			out_q <= {out_q[6:0], 1'b0};
			case (lstate_q)
				L_CMD: begin
					if (byte_end) begin
						if (busy)
							lstate_q <= L_DONE;     // refused, frame ignored
						else if (in_next[7])
							lstate_q <= L_DATA;
						else
							lstate_q <= L_DUMMY;
					end
				end
				L_DATA: begin
					if (byte_end)
						lstate_q <= L_DONE;
				end
				L_DUMMY: begin
					if (byte_end) begin
						lstate_q <= L_DONE;
						out_q    <= busy ? 8'h00 : rd_q; // answer crossed by ack
					end
				end
				L_DONE: lstate_q <= L_DONE;     // extra bytes ignored
				default: lstate_q <= L_CMD;
			endcase
		end
	end

	// a read fires after the command byte, a write after the data byte
	assign fire = byte_end & ((lstate_q == L_CMD & !busy & !in_next[7]) |
		lstate_q == L_DATA);

	// handshake word survives the frame; reset is a constant only
	always_ff @(posedge link_sck or negedge reset_n) begin
		if (!reset_n) begin
			req_q   <= 1'b0;
			lword_q <= '0;
			ack_s   <= 3'h0;
		end else begin
			ack_s <= {ack_s[1:0], ack_q};
			if (fire && lstate_q == L_CMD) begin
				lword_q <= '{wr: 1'b0, addr: in_next[4:0], data: 8'h00};
				req_q   <= ~req_q;
			end else if (fire) begin
				lword_q.data <= in_next;
				lword_q.wr   <= 1'b1;
				req_q        <= ~req_q;
			end else if (lstate_q == L_CMD && byte_end && !busy)
				lword_q.addr <= in_next[4:0];
		end
	end

	// transparent mode hands the pin to the receive stream
	assign serial_out_rx_mod = transparent ? rx_mod_data : out_q[7];
	assign serial_out_en     = transparent | !link_cs_n;

	// pins and the request toggle pass three flops; a change counts
	// once the second and third agree
	wire [8:0] pin_raw = {req_q, serial_in_tx_mod, aux_supply_pin,
		power_on_pin, button_input_n};
	always_ff @(posedge ref_clk) begin
		pin_s1 <= pin_raw;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end
	genvar g;
	generate
		for (g = 0; g < 9; g++) begin : g_pin
			always_ff @(posedge ref_clk) begin
				if (!reset_n)
					pin_q[g] <= (g < 5) ? 1'b1 : 1'b0; // buttons idle high
				else if (pin_s2[g] == pin_s3[g])
					pin_q[g] <= pin_s3[g];
			end
		end
	endgenerate

	// named views of the filtered inputs
	wire        req_f     = pin_q[8];
	wire        sdi_f     = pin_q[7];
	wire        aux_f     = pin_q[6];
	wire        pwr_f     = pin_q[5];
	wire [4:0]  btn_f     = pin_q[4:0];
	wire        req_new   = (req_f != seen_q);
	wire        is_rd     = req_new & !lword_q.wr;  // word stable while request pending
	wire        in_ready  = (cnt_q != FIFO_DEPTH);
	wire        push      = req_new & lword_q.wr & in_ready;
	wire        take      = is_rd | push;           // full buffer holds the ack
	wire        pop       = (cnt_q != 2'h0) & !cfg_hold;
	link_word_t head;
	assign head = fifo_q[rp_q];

	// decode of the buffer head
	wire        hd_buf    = !head.addr[4];
	wire        hd_ctrl   = head.addr[4] & (head.addr[2:0] < 3'(CTRL_NUM)) &
		(head.addr < ADDR_STATUS);
	wire [2:0]  hd_idx    = head.addr[2:0];
	wire        wr_buf    = pop & !off_q & hd_buf & !transparent;
	wire        wr_ctrl   = pop & !off_q & hd_ctrl;
	wire        off_cmd   = pop & !off_q & head.addr == ADDR_OFF_CMD;
	wire        pins_idle = !pwr_f & (&btn_f);
	wire        go_off    = off_cmd & !analog_supply & pins_idle;
	wire        wake_ev   = pwr_f | !(&btn_f) | aux_f;
	wire        turn_on   = off_q & wake_ev;
	wire        clr_all   = go_off | turn_on;

	// handshake answer and read data
	wire [7:0]  status_v  = {4'h0, wake_q, irq_q};
	wire [7:0]  ctrl_rd   = (lword_q.addr[2:0] < 3'(CTRL_NUM)) ?
		ctrl_q[lword_q.addr[2:0]] : 8'h00;
	wire [7:0]  rd_mux    = !lword_q.addr[4] ? buf_q[lword_q.addr[3:0]] :
		(lword_q.addr == ADDR_STATUS) ? status_v :
		(lword_q.addr < ADDR_STATUS) ? ctrl_rd : 8'h00;
	wire        stat_rd   = is_rd & !off_q & lword_q.addr == ADDR_STATUS;
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			seen_q <= 1'b0;
			ack_q  <= 1'b0;
			rd_q   <= 8'h00;
		end else if (take) begin
			seen_q <= req_f;
			ack_q  <= ~ack_q;
			if (is_rd)
				rd_q <= off_q ? 8'h00 : rd_mux;  // not readable while off
		end
	end

	// two-entry write buffer; cfg_hold stalls the drain
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push)
				wp_q <= ~wp_q;
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			fifo_q[0] <= '0;
			fifo_q[1] <= '0;
		end else if (push)
			fifo_q[wp_q] <= lword_q;
	end

	// storage: contents lost at off, defaults at turn-on
	generate
		for (g = 0; g < BUF_NUM; g++) begin : g_buf
			always_ff @(posedge ref_clk) begin
				if (!reset_n || clr_all)
					buf_q[g] <= 8'h00;
				else if (wr_buf && head.addr[3:0] == 4'(g))
					buf_q[g] <= head.data;
			end
		end
		for (g = 0; g < CTRL_NUM; g++) begin : g_ctrl
			always_ff @(posedge ref_clk) begin
				if (!reset_n || clr_all)
					ctrl_q[g] <= CTRL_RST[g];
				else if (wr_ctrl && hd_idx == 3'(g))
					ctrl_q[g] <= head.data;
			end
		end
	endgenerate

	// off mode and wake cause
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			off_q  <= 1'b0;
			wake_q <= 3'h0;
		end else if (go_off) begin
			off_q  <= 1'b1;
			wake_q <= 3'h0;
		end else if (turn_on) begin
			off_q  <= 1'b0;
			wake_q <= {aux_f, !(&btn_f), pwr_f};
		end
	end

	// configuration fields
	wire [7:0]  cfg0     = ctrl_q[REG_MODE_IRQ];
	wire [7:0]  cfg1     = ctrl_q[REG_FREQ_LOW];
	wire [1:0]  thr_sel  = {cfg0[IRQ_HI_BIT], cfg0[IRQ_LO_BIT]};
	wire        pmode    = cfg1[PMODE_BIT];
	wire [4:0]  thr_cnt  = (thr_sel == 2'h0) ? THR_4 :
		(thr_sel == 2'h1) ? THR_8 : THR_12;
	wire        is_rx    = (op_sel == OP_RX) | (op_sel == OP_RX_POLL);
	wire        is_tx    = (op_sel == OP_TX);
	wire        thr_on   = (thr_sel != THR_NONE);
	wire        rx_irq   = is_rx & (rx_error | (thr_on & fill_count >= thr_cnt) |
		(bit_check_ok & !pmode));
	wire        tx_irq   = is_tx & (tx_empty | (thr_on & fill_count == thr_cnt));
	wire        irq_set  = !off_q & (rx_irq | tx_irq);

	// sticky interrupt; a new event wins over the status read clear
	always_ff @(posedge ref_clk) begin
		if (!reset_n || off_q)
			irq_q <= 1'b0;
		else
			irq_q <= irq_set | (irq_q & !stat_rd);
	end

	// registered outputs
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tx_mod_data <= 1'b0;
			freq_word   <= {RST_CTRL_2[FHI_MSB:FHI_LSB], RST_FREQ_LOW[FREQ_MSB:FREQ_LSB]};
		end else begin
			tx_mod_data <= transparent & sdi_f;
			// each step moves the carrier by xtal / FREQ_STEP_DIV
			freq_word   <= {ctrl_q[REG_FREQ_HIGH][FHI_MSB:FHI_LSB],
				cfg1[FREQ_MSB:FREQ_LSB]};
		end
	end

	// mode outputs straight from the stored bits
	assign irq           = irq_q;
	assign analog_supply = cfg0[ANALOG_BIT] & !off_q;
	assign band_select   = cfg0[BAND_BIT];
	assign op_sel        = op_mode_t'({cfg0[OP_HI_BIT], cfg0[OP_LO_BIT]});
	assign transparent   = cfg0[TRANSP_BIT];
	assign manchester_on = is_tx & !pmode;
	assign digital_on    = !off_q;

	// checks, all on the core clock
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_ack_cause: assert property ($changed(ack_q) |-> $past(req_new))
		else $error("ack toggled with no request");
	chk_fifo_bound: assert property (cnt_q == FIFO_DEPTH |-> !push)
		else $error("write buffer overrun");
	chk_ctrl_write: assert property (wr_ctrl && hd_idx == REG_MODE_IRQ &&
		!clr_all |=> ctrl_q[REG_MODE_IRQ] == $past(head.data))
		else $error("control write lost");
	chk_reset_default: assert property ($rose(reset_n) |->
		cfg0 == RST_MODE_IRQ && cfg1 == RST_FREQ_LOW)
		else $error("control default wrong");
	chk_rx_threshold: assert property (!off_q && is_rx && thr_on &&
		fill_count >= thr_cnt |=> irq_q)
		else $error("receive threshold missed");
	chk_tx_empty_irq: assert property (!off_q && is_tx && tx_empty |=> irq_q)
		else $error("transmit empty missed");
	chk_bitchk_mask: assert property (!off_q && is_rx && bit_check_ok &&
		!pmode |=> irq_q)
		else $error("bit check irq missed");
	chk_nrz_select: assert property (is_tx && pmode |-> !manchester_on)
		else $error("coding wrong");
	chk_transp_buf: assert property (pop && hd_buf && transparent &&
		!clr_all |=> buf_q[$past(head.addr[3:0])] == $past(buf_q[head.addr[3:0]]))
		else $error("buffer written in transparent mode");
	// the pin clears one cycle after off is entered, a late event may still land
	chk_off_guard: assert property (go_off |-> !analog_supply && !pwr_f
		##1 off_q ##1 irq == 1'b0)
		else $error("off entered badly");

	cov_read: cover property (is_rd ##1 $changed(ack_q));
	cov_full: cover property (cnt_q == FIFO_DEPTH && req_new);
	cov_off: cover property (go_off ##[1:1000] turn_on);
	cov_irq_clear: cover property (irq_q && stat_rd ##1 !irq_q);
endmodule // xcvr_cfg_regs
`default_nettype wire

// ---- inc/xcvr_cfg_pkg.sv ----
// Purpose: shared constants and types of the transceiver configuration store
// Assumes: link words carry a write flag, a 5-bit address and one data byte
// Notes:   control register resets below are the power-up defaults
`default_nettype none
package xcvr_cfg_pkg;
	localparam int          BUF_NUM       = 16;        // data buffer entries
	localparam int          CTRL_NUM      = 6;         // control bytes
	localparam logic [2:0]  REG_MODE_IRQ  = 3'h0;      // mode_irq_config index
	localparam logic [2:0]  REG_FREQ_LOW  = 3'h1;      // freq_tune_low index
	localparam logic [2:0]  REG_FREQ_HIGH = 3'h2;      // next control byte
	localparam logic [4:0]  CTRL_BASE     = 5'h10;     // control space start
	localparam logic [4:0]  ADDR_STATUS   = 5'h16;     // read-only status
	localparam logic [4:0]  ADDR_OFF_CMD  = 5'h17;     // off command
	localparam int          IRQ_HI_BIT    = 7;         // irq_level_hi
	localparam int          IRQ_LO_BIT    = 6;         // irq_level_lo
	localparam int          ANALOG_BIT    = 5;         // analog_supply_on
	localparam int          BAND_BIT      = 4;         // band_select
	localparam int          OP_HI_BIT     = 2;         // op_sel_hi
	localparam int          OP_LO_BIT     = 1;         // op_sel_lo
	localparam int          TRANSP_BIT    = 0;         // transparent mode
	localparam int          FREQ_MSB      = 7;         // freq_word_bit6
	localparam int          FREQ_LSB      = 1;         // freq_word_bit0
	localparam int          PMODE_BIT     = 0;         // bit-check irq / nrz
	localparam int          FHI_MSB       = 7;         // high tuning bits
	localparam int          FHI_LSB       = 2;
	localparam int          FREQ_STEP_DIV = 16384;     // rf step = xtal / this
	localparam logic [7:0]  RST_MODE_IRQ  = 8'h80;     // threshold 12, idle
	localparam logic [7:0]  RST_FREQ_LOW  = 8'hb0;     // low value 88
	localparam logic [7:0]  RST_CTRL_2    = 8'h7b;     // high 3840, out, clk on
	localparam logic [7:0]  RST_CTRL_3    = 8'h28;     // sleep 10
	localparam logic [7:0]  RST_CTRL_4    = 8'h50;     // check 3, limit 16
	localparam logic [7:0]  RST_CTRL_5    = 8'h00;
	localparam logic [CTRL_NUM-1:0][7:0] CTRL_RST = {RST_CTRL_5, RST_CTRL_4,
		RST_CTRL_3, RST_CTRL_2, RST_FREQ_LOW, RST_MODE_IRQ};
	localparam logic [4:0]  THR_4         = 5'h04;     // threshold counts
	localparam logic [4:0]  THR_8         = 5'h08;
	localparam logic [4:0]  THR_12        = 5'h0c;
	localparam logic [1:0]  THR_NONE      = 2'h3;      // error, bit check / empty only
	localparam logic [1:0]  FIFO_DEPTH    = 2'h2;      // write buffer entries

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00, OP_TX = 2'b01, OP_RX_POLL = 2'b10, OP_RX = 2'b11
	} op_mode_t;

	typedef enum logic [1:0] {                          // gray along paths except refused cmd to done
		L_CMD = 2'b00, L_DATA = 2'b01, L_DONE = 2'b11, L_DUMMY = 2'b10
	} link_state_t;

	typedef struct packed {
		logic       wr;                                  // 1 = write
		logic [4:0] addr;                                // target address
		logic [7:0] data;                                // write data
	} link_word_t;
endpackage
`default_nettype wire

// ---- dv/link_host_model.sv ----
// Purpose: host side of the 4-wire configuration link
// Assumes: device samples on the rising link clock edge, msb first
// Notes:   link clock stands low between frames, 125 ns period
`timescale 1ns/10ps
`default_nettype none
module link_host_model (
	output logic      link_sck,  // link clock, low outside frames
	output logic      link_cs_n, // frame select, low active
	output logic      sdi,       // data towards device
	input  wire logic sdo,       // data from device
	input  wire logic sdo_en     // device drives sdo
);
	localparam realtime HALF = 62.5; // half link period

	// idle levels; a short select pulse clears the frame logic, since a
	// level set at time zero may race the device's asynchronous clear
	initial begin
		link_sck  = 1'b0;
		link_cs_n = 1'b0;
		sdi       = 1'b0;
		#1;
		link_cs_n = 1'b1;
	end

	// transparent stream bit, held between frames
	task automatic set_stream(input logic b);
		sdi = b;
	endtask

	// one frame: cmd byte, data or dummy byte, answer byte on reads
	task automatic xfer(input logic wr, input logic [4:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		logic [23:0] sh;
		int          n;
		sh        = {wr, 2'h0, addr, wdata, 8'h00};
		n         = wr ? 16 : 24;
		rdata     = 8'h00;
		link_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi = sh[23-i]; // changes away from the sampling edge
			#HALF;
			link_sck = 1'b1;
			#HALF;
			link_sck = 1'b0;
			// an undriven line reads as unknown, so a silent device cannot pass
			if (i >= 15 && i < 23) begin
				rdata = {rdata[6:0], sdo_en ? sdo : 1'bx};
			end
		end
		#HALF;
		link_cs_n = 1'b1;
		sdi       = ~sdi; // released line never repeats the last bit
		#1000; // gap of at least 1 us before the next frame
	endtask
endmodule // link_host_model
`default_nettype wire

// ---- dv/xcvr_cfg_regs_tb_top.sv ----
// Purpose: self-checking bench of the configuration store
// Assumes: host model runs frames, bench drives the core-side inputs
// Notes:   every scenario judges its own results before returning
`timescale 1ns/10ps
`default_nettype none
module xcvr_cfg_regs_tb_top;
	import xcvr_cfg_pkg::*;
	localparam logic [4:0] A_MODE = CTRL_BASE + 5'(REG_MODE_IRQ); // mode_irq_config
	localparam logic [4:0] A_FREQ = CTRL_BASE + 5'(REG_FREQ_LOW); // freq_tune_low
	localparam int         LIMIT  = 80000;                        // cycle ceiling
	logic ref_clk, reset_n, link_sck, link_cs_n, sdi, sdo, sdo_en;       // clocks, link
	logic power_on_pin, aux_supply_pin, cfg_hold, rx_error, bit_check_ok; // core inputs
	logic tx_empty, rx_mod_data, tx_mod_data, irq, analog_supply;        // misc
	logic band_select, transparent, manchester_on, digital_on;          // decoded outputs
	logic [4:0]  button_input_n, fill_count;                             // wake, fill level
	logic [12:0] freq_word;                                              // tuning word
	op_mode_t    op_sel;                                                 // mode
	logic [7:0]  rd_v, st_v;                                             // read results
	int          error_cnt, checks_done, cyc;                            // counters

	xcvr_cfg_regs xcvr_cfg_regs_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.link_sck(link_sck), .link_cs_n(link_cs_n), .serial_in_tx_mod(sdi),
		.serial_out_rx_mod(sdo), .serial_out_en(sdo_en), .power_on_pin(power_on_pin),
		.button_input_n(button_input_n), .aux_supply_pin(aux_supply_pin),
		.cfg_hold(cfg_hold), .fill_count(fill_count), .rx_error(rx_error),
		.bit_check_ok(bit_check_ok), .tx_empty(tx_empty), .rx_mod_data(rx_mod_data),
		.tx_mod_data(tx_mod_data), .irq(irq), .analog_supply(analog_supply),
		.band_select(band_select), .op_sel(op_sel), .transparent(transparent),
		.freq_word(freq_word), .manchester_on(manchester_on), .digital_on(digital_on));
	link_host_model link_host_model_i (.link_sck(link_sck), .link_cs_n(link_cs_n),
		.sdi(sdi), .sdo(sdo), .sdo_en(sdo_en));

	// 100 mhz core clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// hang guard: a run past the ceiling counts as a mismatch
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			wrap_up();
		end
	end

	// inputs always move 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		link_host_model_i.xfer(1'b1, a, d, rd_v);
		step(1);
	endtask
	task automatic rd(input logic [4:0] a);
		link_host_model_i.xfer(1'b0, a, 8'h00, rd_v);
		step(1);
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h0, got}, {7'h0, exp});
	endtask
	task automatic chk_word(input logic [12:0] got, input logic [12:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// wait out the filter and flop, then look at the pin
	task automatic irq_is(input logic e);
		step(6);
		chk_bit(irq, e);
	endtask
	// a status read clears the pending interrupt
	task automatic irq_clear();
		rd(ADDR_STATUS);
		chk_bit(irq, 1'b0);
	endtask

	task automatic t_defaults();
		chk_word(freq_word, 13'd3928);
		chk_bit(analog_supply, 1'b0);
		chk_bit(band_select, 1'b0);
		chk_byte({6'h0, op_sel}, 8'h00);
		chk_bit(transparent, 1'b0);
		rd(A_MODE);
		chk_byte(rd_v, 8'h80);
		rd(A_FREQ);
		chk_byte(rd_v, 8'hb0);
		$display("test defaults done");
	endtask

	// every mode code, with supply, band and spare bit set
	task automatic t_fields();
		for (int m = 0; m < 4; m++) begin
			wr(A_MODE, {5'b10111, 2'(m), 1'b0});
			chk_bit(analog_supply, 1'b1);
			chk_bit(band_select, 1'b1);
			chk_byte({6'h0, op_sel}, 8'(m));
			rd(A_MODE);
			chk_byte(rd_v, {5'b10111, 2'(m), 1'b0});
		end
		wr(A_MODE, 8'h80);
		chk_bit(band_select, 1'b0);
		rd(A_MODE);
		chk_byte(rd_v, 8'h80);
		$display("test fields done");
	endtask

	// low tuning value at both ends, coding bit alternating in transmit
	task automatic t_freq();
		logic [6:0] v [3] = '{7'd0, 7'd127, 7'd1};
		wr(A_MODE, 8'h82);
		for (int i = 0; i < 3; i++) begin
			wr(A_FREQ, {v[i], i[0]});
			chk_word(freq_word, 13'd3840 + 13'(v[i]));
			chk_bit(manchester_on, ~i[0]);
			rd(A_FREQ);
			chk_byte(rd_v, {v[i], i[0]});
		end
		$display("test freq done");
	endtask

	// buffer storage and a write attempt on the read-only status
	task automatic t_storage();
		wr(5'h05, 8'ha5);
		wr(5'h0f, 8'h5a);
		rd(5'h05);
		chk_byte(rd_v, 8'ha5);
		rd(5'h0f);
		chk_byte(rd_v, 8'h5a);
		wr(CTRL_BASE + 5'h05, 8'h3c);
		rd(CTRL_BASE + 5'h05);
		chk_byte(rd_v, 8'h3c);
		rd(ADDR_STATUS);
		st_v = rd_v;
		wr(ADDR_STATUS, ~st_v);
		rd(ADDR_STATUS);
		chk_byte(rd_v, st_v);
		$display("test storage done");
	endtask

	task automatic t_irq_rx();
		int thr [3] = '{4, 8, 12};
		for (int t = 0; t < 3; t++) begin
			wr(A_MODE, {2'(t), 5'b00011, 1'b0});
			fill_count = 5'(thr[t] - 1);
			irq_is(1'b0);
			fill_count = 5'(thr[t]);
			irq_is(1'b1);
			fill_count = 5'h00;
			irq_clear();
		end
		wr(A_MODE, 8'hc6);
		fill_count = 5'h10;
		irq_is(1'b0);
		fill_count = 5'h00;
		rx_error = 1'b1;
		step(1);
		rx_error = 1'b0;
		irq_is(1'b1);
		irq_clear();
		bit_check_ok = 1'b1;
		step(1);
		bit_check_ok = 1'b0;
		irq_is(1'b1);
		irq_clear();
		wr(A_FREQ, 8'h01);
		bit_check_ok = 1'b1;
		step(1);
		bit_check_ok = 1'b0;
		irq_is(1'b0);
		$display("test irq rx done");
	endtask

	task automatic t_irq_tx();
		wr(A_MODE, 8'h02);
		fill_count = 5'h05;
		irq_is(1'b0);
		fill_count = 5'h04;
		irq_is(1'b1);
		fill_count = 5'h00;
		irq_clear();
		tx_empty = 1'b1;
		irq_is(1'b1);
		tx_empty = 1'b0;
		irq_clear();
		wr(A_MODE, 8'hc2);
		fill_count = 5'h04;
		irq_is(1'b0);
		fill_count = 5'h00;
		$display("test irq tx done");
	endtask

	// bypass: pins carry the streams and the buffer ignores writes
	task automatic t_transparent();
		wr(A_MODE, 8'h83);
		chk_bit(transparent, 1'b1);
		for (int b = 0; b < 2; b++) begin
			link_host_model_i.set_stream(b[0]);
			rx_mod_data = ~b[0];
			step(6);
			chk_bit(tx_mod_data, b[0]);
			chk_bit(sdo, ~b[0]);
			chk_bit(sdo_en, 1'b1);
		end
		wr(5'h05, 8'h3c);
		wr(A_MODE, 8'h80);
		rd(5'h05);
		chk_byte(rd_v, 8'ha5);
		$display("test transparent done");
	endtask

	// stalled drain: two words wait, the third is held, none is lost
	task automatic t_stall();
		cfg_hold = 1'b1;
		wr(A_MODE, 8'h90);
		wr(A_FREQ, 8'h22);
		wr(5'h02, 8'h77);
		chk_bit(band_select, 1'b0);
		cfg_hold = 1'b0;
		step(20);
		chk_bit(band_select, 1'b1);
		rd(A_FREQ);
		chk_byte(rd_v, 8'h22);
		rd(5'h02);
		chk_byte(rd_v, 8'h77);
		$display("test stall done");
	endtask

	// off refused with supply on; then off and each wake source in turn
	task automatic t_power();
		wr(A_MODE, 8'ha0);
		chk_bit(analog_supply, 1'b1);
		wr(ADDR_OFF_CMD, 8'h00);
		chk_bit(digital_on, 1'b1);
		for (int w = 0; w < 3; w++) begin
			wr(A_MODE, 8'h12);
			wr(ADDR_OFF_CMD, 8'h00);
			chk_bit(digital_on, 1'b0);
			rd(A_MODE);
			chk_byte(rd_v, 8'h00);
			power_on_pin   = (w == 0);
			button_input_n = (w == 1) ? 5'h1e : 5'h1f;
			aux_supply_pin = (w == 2);
			step(10);
			power_on_pin   = 1'b0;
			button_input_n = 5'h1f;
			aux_supply_pin = 1'b0;
			step(10);
			chk_bit(digital_on, 1'b1);
			rd(A_MODE);
			chk_byte(rd_v, 8'h80);
			rd(5'h05);
			chk_byte(rd_v, 8'h00);
			irq_clear();
			chk_byte(rd_v, {4'h0, 3'(1 << w), 1'b0});
		end
		$display("test power done");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// main sequence: quiet inputs, 8-cycle reset, then each scenario
	initial begin
		{reset_n, power_on_pin, aux_supply_pin, cfg_hold} = 4'h8;
		{rx_error, bit_check_ok, tx_empty, rx_mod_data} = 4'h0;
		button_input_n = 5'h1f;
		fill_count     = 5'h00;
		error_cnt      = 0;
		checks_done    = 0;
		cyc            = 0;
		// a real falling edge, so the link-side flops see their clear
		#1;
		reset_n        = 1'b0;
		step(8);
		reset_n = 1'b1;
		step(2);
		t_defaults();
		t_fields();
		t_freq();
		t_storage();
		t_irq_rx();
		t_irq_tx();
		t_transparent();
		t_stall();
		t_power();
		wrap_up();
	end
endmodule // xcvr_cfg_regs_tb_top
`default_nettype wire
